/* File: hdl/tcpr_defines.svh */
// Purpose: constants for the thermal charge profile register block
// Assumes: 8-bit register bus, byte addresses
// Notes: definitions only
`ifndef TCPR_DEFINES_SVH
`define TCPR_DEFINES_SVH

`define TCPR_ADDR_PROFILE 8'h0C
`define TCPR_ADDR_RESET_CTRL 8'h0B
`define TCPR_RESET_CTRL_BIT 7
`define TCPR_PROFILE_RESET 8'h75
`define TCPR_COOL_MSB 7
`define TCPR_COOL_LSB 6
`define TCPR_WARM_MSB 5
`define TCPR_WARM_LSB 4
`define TCPR_CBND_MSB 3
`define TCPR_CBND_LSB 2
`define TCPR_WBND_MSB 1
`define TCPR_WBND_LSB 0
// thresholds in hundredths of a percent of the thermistor ratio
`define TCPR_CBND_00 14'd7075
`define TCPR_CBND_01 14'd6825
`define TCPR_CBND_10 14'd6525
`define TCPR_CBND_11 14'd6225
`define TCPR_WBND_00 14'd4825
`define TCPR_WBND_01 14'd4475
`define TCPR_WBND_10 14'd4075
`define TCPR_WBND_11 14'd3775
// scale in percent of the fast charge current
`define TCPR_PCT_OFF 7'd0
`define TCPR_PCT_20 7'd20
`define TCPR_PCT_50 7'd50
`define TCPR_PCT_FULL 7'd100

`endif

/* File: hdl/tcpr_pkg.sv */
// Purpose: types for the thermal charge profile register block
// Assumes: nothing
// Notes: constants live in tcpr_defines.svh
package tcpr_pkg;
	typedef enum logic [1:0] {
		TCPR_SCALE_OFF = 2'h0,
		TCPR_SCALE_20 = 2'h1,
		TCPR_SCALE_50 = 2'h2,
		TCPR_SCALE_FULL = 2'h3
	} tcpr_scale_t;
	typedef enum logic [2:0] {
		TCPR_RANGE_NORMAL = 3'h1,
		TCPR_RANGE_COOL = 3'h2,
		TCPR_RANGE_WARM = 3'h4
	} tcpr_range_t;
endpackage

/* File: hdl/tcpr_scale_decode.sv */
// Purpose: decode one current scale field into a percentage
// Assumes: combinational use
// Notes: shared by cool and warm fields
`timescale 1ns/1ns
`default_nettype none
`include "tcpr_defines.svh"
module tcpr_scale_decode (
	input wire tcpr_pkg::tcpr_scale_t code, // two-bit scale field
	output logic [6:0] pct, // percent of fast charge current
	output logic full // full current selected
);
	import tcpr_pkg::*;
	// -------------------------------------------------
	// decode
	// -------------------------------------------------
	always_comb begin
		full = 1'b0;
		case (code)
			TCPR_SCALE_OFF: pct = `TCPR_PCT_OFF;
			TCPR_SCALE_20: pct = `TCPR_PCT_20;
			TCPR_SCALE_50: pct = `TCPR_PCT_50;
			TCPR_SCALE_FULL: begin
				pct = `TCPR_PCT_FULL;
				full = 1'b1;
			end
			default: pct = `TCPR_PCT_OFF;
		endcase
	end
endmodule // tcpr_scale_decode
`default_nettype wire

/* File: hdl/thermal_charge_profile_regs.sv */
// Purpose: charge profile register at 0Ch with range selection outputs
// Assumes: serial bus decoder supplies one-cycle byte strobes; inputs synchronous
// Notes: range decided each cycle from the programmed boundaries
// Operation
// - bits 7:6 pick cool range current: off, 20, 50 or 100 percent; default 01
// - bits 5:4 pick warm range current with same encoding; default 11
// - full current in the active range forbids doubling the safety timer
// - bits 3:2 set cool boundary ratio 70.75/68.25/65.25/62.25 percent
// - bits 1:0 set warm boundary ratio 48.25/44.75/40.75/37.75 percent
// - register at 0Ch, all bits read/write, reset value 75h
// - register reset bit restores defaults, resets safety timer, then clears itself
// - watchdog expiry restores defaults and raises watchdog fault status
`timescale 1ns/1ns
`default_nettype none
`include "tcpr_defines.svh"
module thermal_charge_profile_regs (
	input wire logic clk, // 100 MHz clock
	input wire logic rst, // synchronous reset, active high
	input wire logic ce, // clock enable, freezes state when low
	input wire logic [7:0] reg_addr, // register address from bus decoder
	input wire logic [7:0] reg_wdata, // write data byte
	input wire logic reg_wr, // write strobe, one cycle
	input wire logic reg_rd, // read strobe, one cycle
	output logic [7:0] reg_rdata, // read data byte, registered
	output logic reg_hit, // address is served by this block
	input wire logic wdog_expired, // watchdog expiry pulse
	input wire logic wdog_service, // host serviced watchdog, clears watchdog fault status
	input wire logic [13:0] ts_ratio, // thermistor ratio, hundredths of percent
	output logic [6:0] cool_range_current_scale, // percent applied in cool range
	output logic [6:0] warm_range_current_scale, // percent applied in warm range
	output logic [6:0] active_current_scale, // percent for present range
	output tcpr_pkg::tcpr_range_t temp_range, // present range, registered
	output logic timer_double_ok, // safety timer may run at double length
	output logic safety_timer_reset, // one-cycle safety timer reset pulse
	output logic wdog_fault // watchdog fault status, sticky
);
	import tcpr_pkg::*;

	// -------------------------------------------------
	// register state
	// -------------------------------------------------
	logic [7:0] profile_ff, nxt_profile;
	logic rst_req_ff, nxt_rst_req;
	logic wdog_fault_ff, nxt_wdog_fault;
	logic tmr_rst_ff, nxt_tmr_rst;
	logic [7:0] rdata_ff, nxt_rdata;
	logic hit_prof, hit_ctrl;

	assign hit_prof = (reg_addr == `TCPR_ADDR_PROFILE);
	assign hit_ctrl = (reg_addr == `TCPR_ADDR_RESET_CTRL);
	assign reg_hit = hit_prof | hit_ctrl;

	// next values: defaults win over a same-cycle write, fault set wins over clear
	always_comb begin
		nxt_profile = profile_ff;
		nxt_rst_req = 1'b0; // self clear after one cycle
		nxt_tmr_rst = 1'b0;
		nxt_wdog_fault = wdog_fault_ff;
		nxt_rdata = rdata_ff;
		if (reg_wr && hit_prof) begin
			nxt_profile = reg_wdata;
		end
		if (reg_wr && hit_ctrl && reg_wdata[`TCPR_RESET_CTRL_BIT]) begin
			nxt_rst_req = 1'b1;
		end
		if (rst_req_ff) begin
			nxt_profile = `TCPR_PROFILE_RESET;
			nxt_tmr_rst = 1'b1;
		end
		if (wdog_service) begin
			nxt_wdog_fault = 1'b0;
		end
		if (wdog_expired) begin
			nxt_profile = `TCPR_PROFILE_RESET;
			nxt_wdog_fault = 1'b1;
		end
		if (reg_rd) begin
			if (hit_prof) begin
				nxt_rdata = profile_ff;
			end else if (hit_ctrl) begin
				nxt_rdata = {rst_req_ff, 7'h00};
			end else begin
				nxt_rdata = 8'h00;
			end
		end
	end

	// registers only
	always_ff @(posedge clk) begin
		if (rst) begin
			profile_ff <= `TCPR_PROFILE_RESET;
			rst_req_ff <= 1'b0;
			tmr_rst_ff <= 1'b0;
			wdog_fault_ff <= 1'b0;
			rdata_ff <= 8'h00;
		end else if (ce) begin
			profile_ff <= nxt_profile;
			rst_req_ff <= nxt_rst_req;
			tmr_rst_ff <= nxt_tmr_rst;
			wdog_fault_ff <= nxt_wdog_fault;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign wdog_fault = wdog_fault_ff;
	assign safety_timer_reset = tmr_rst_ff;

	// -------------------------------------------------
	// field decode
	// -------------------------------------------------
	logic cool_full, warm_full;
	logic [13:0] cool_bnd, warm_bnd;

	tcpr_scale_decode u_cool (
		.code(tcpr_scale_t'(profile_ff[`TCPR_COOL_MSB:`TCPR_COOL_LSB])),
		.pct(cool_range_current_scale),
		.full(cool_full)
	);
	tcpr_scale_decode u_warm (
		.code(tcpr_scale_t'(profile_ff[`TCPR_WARM_MSB:`TCPR_WARM_LSB])),
		.pct(warm_range_current_scale),
		.full(warm_full)
	);

	// boundary tables
	always_comb begin
		case (profile_ff[`TCPR_CBND_MSB:`TCPR_CBND_LSB])
			2'h0: cool_bnd = `TCPR_CBND_00;
			2'h1: cool_bnd = `TCPR_CBND_01;
			2'h2: cool_bnd = `TCPR_CBND_10;
			2'h3: cool_bnd = `TCPR_CBND_11;
			default: cool_bnd = `TCPR_CBND_01;
		endcase
		case (profile_ff[`TCPR_WBND_MSB:`TCPR_WBND_LSB])
			2'h0: warm_bnd = `TCPR_WBND_00;
			2'h1: warm_bnd = `TCPR_WBND_01;
			2'h2: warm_bnd = `TCPR_WBND_10;
			2'h3: warm_bnd = `TCPR_WBND_11;
			default: warm_bnd = `TCPR_WBND_01;
		endcase
	end

	// -------------------------------------------------
	// range selection
	// -------------------------------------------------
	// ntc ratio falls as temperature rises, so a high ratio means cool
	tcpr_range_t range_ff, nxt_range;

	always_comb begin
		if (ts_ratio >= cool_bnd) begin
			nxt_range = TCPR_RANGE_COOL;
		end else if (ts_ratio <= warm_bnd) begin
			nxt_range = TCPR_RANGE_WARM;
		end else begin
			nxt_range = TCPR_RANGE_NORMAL;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			range_ff <= TCPR_RANGE_NORMAL;
		end else if (ce) begin
			range_ff <= nxt_range;
		end
	end

	assign temp_range = range_ff;

	// scale and timer doubling follow the registered range
	always_comb begin
		case (range_ff)
			TCPR_RANGE_COOL: begin
				active_current_scale = cool_range_current_scale;
				timer_double_ok = ~cool_full;
			end
			TCPR_RANGE_WARM: begin
				active_current_scale = warm_range_current_scale;
				timer_double_ok = ~warm_full;
			end
			TCPR_RANGE_NORMAL: begin
				active_current_scale = `TCPR_PCT_FULL;
				timer_double_ok = 1'b0;
			end
			default: begin
				active_current_scale = `TCPR_PCT_FULL;
				timer_double_ok = 1'b0;
			end
		endcase
	end
endmodule // thermal_charge_profile_regs
`default_nettype wire

/* File: test/tcpr_assertions.sv */
// Purpose: port checker for the charge profile register
// Assumes: ports as the top module declares them
// Notes: bound after the module
`timescale 1ns/1ns
`default_nettype none
module tcpr_chk (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic ce, // enable
	input wire logic [7:0] reg_addr, // address
	input wire logic [7:0] reg_wdata, // data
	input wire logic reg_wr, // write
	input wire logic [7:0] reg_rdata, // read data
	input wire logic reg_rd, // read
	input wire logic reg_hit, // hit
	input wire logic wdog_expired, // expiry
	input wire logic wdog_service, // service
	input wire logic [6:0] cool_range_current_scale, // cool pct
	input wire logic [6:0] warm_range_current_scale, // warm pct
	input wire logic [6:0] active_current_scale, // active pct
	input wire tcpr_pkg::tcpr_range_t temp_range, // range
	input wire logic timer_double_ok, // doubling allowed
	input wire logic safety_timer_reset, // timer reset
	input wire logic wdog_fault // fault
);
	import tcpr_pkg::*;
	// percent implied by a scale code
	function automatic logic [6:0] pct(logic [1:0] c);
		return c == 2'h0 ? 7'd0 : c == 2'h1 ? 7'd20 : c == 2'h2 ? 7'd50 : 7'd100;
	endfunction
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// expiry is excluded, it beats a same-cycle write
	sequence s_wr;
		ce && reg_wr && reg_addr == 8'h0C && !wdog_expired;
	endsequence
	sequence s_rrst;
		ce && reg_wr && reg_addr == 8'h0B && reg_wdata[7] && !wdog_expired;
	endsequence
	sequence s_dflt;
		cool_range_current_scale == 7'd20 && warm_range_current_scale == 7'd100;
	endsequence
	a_cool_scale: assert property (
		s_wr |=> cool_range_current_scale == pct($past(reg_wdata[7:6])))
		else $error("cool scale wrong");
	a_warm_scale: assert property (
		s_wr |=> warm_range_current_scale == pct($past(reg_wdata[5:4])))
		else $error("warm scale wrong");
	a_cool_path: assert property (
		temp_range == TCPR_RANGE_COOL |-> active_current_scale == cool_range_current_scale
		&& timer_double_ok == (cool_range_current_scale != 7'd100))
		else $error("cool path wrong");
	a_warm_path: assert property (
		temp_range == TCPR_RANGE_WARM |-> active_current_scale == warm_range_current_scale
		&& timer_double_ok == (warm_range_current_scale != 7'd100))
		else $error("warm path wrong");
	a_reg_reset: assert property (
		s_rrst |=> ##1 safety_timer_reset ##0 s_dflt ##1 !safety_timer_reset)
		else $error("register reset wrong");
	a_wdog_load: assert property (
		ce && wdog_expired |=> wdog_fault ##0 s_dflt)
		else $error("watchdog load wrong");
	a_fault_hold: assert property (
		wdog_fault && !wdog_service |=> wdog_fault)
		else $error("fault lost");
	a_unmapped_rd: assert property (
		ce && reg_rd && !reg_hit |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule // tcpr_chk
bind thermal_charge_profile_regs tcpr_chk u_chk (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
	.reg_rd, .reg_hit, .wdog_expired, .wdog_service, .cool_range_current_scale, .warm_range_current_scale,
	.active_current_scale, .temp_range, .timer_double_ok, .safety_timer_reset, .wdog_fault);
`default_nettype wire

/* File: test/tcpr_host.sv */
// Purpose: host side of the register strobes
// Assumes: one-cycle strobes, driven after an edge
// Notes: idle address and data are inverted so stale values never match
`timescale 1ns/1ns
`default_nettype none
module tcpr_host (
	input wire logic clk, // clock
	input wire logic [7:0] reg_rdata, // read data
	output logic [7:0] reg_addr = 8'h00, // address
	output logic [7:0] reg_wdata = 8'h00, // write data
	output logic reg_wr = 1'b0, // write strobe
	output logic reg_rd = 1'b0 // read strobe
);
	// single byte write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// data lands on the strobe's taking edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask
endmodule // tcpr_host
`default_nettype wire

/* File: test/tb_thermal_charge_profile_regs.sv */
// Purpose: self-checking bench for the charge profile register
// Assumes: 100 MHz clock, host model drives the strobes
// Notes: expectations come from the field tables
`timescale 1ns/1ns
`default_nettype none
module tb_thermal_charge_profile_regs;
	import tcpr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wdog_expired = 1'b0, wdog_service = 1'b0;
	logic [13:0] ts_ratio = 14'd5000;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
	logic reg_wr, reg_rd, reg_hit, timer_double_ok, safety_timer_reset, wdog_fault;
	logic [6:0] cool_range_current_scale, warm_range_current_scale, active_current_scale;
	tcpr_range_t temp_range;
	int mismatches = 0, comparisons = 0, cyc = 0;
	logic [6:0] pt [4] = '{7'd0, 7'd20, 7'd50, 7'd100};
	logic [13:0] cb [4] = '{14'd7075, 14'd6825, 14'd6525, 14'd6225};
	logic [13:0] wb [4] = '{14'd4825, 14'd4475, 14'd4075, 14'd3775};
	thermal_charge_profile_regs dut (.clk, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.reg_hit, .wdog_expired, .wdog_service, .ts_ratio, .cool_range_current_scale, .warm_range_current_scale,
		.active_current_scale, .temp_range, .timer_double_ok, .safety_timer_reset, .wdog_fault);
	tcpr_host host (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
	initial forever #5 clk = ~clk;
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic final_report;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// range is registered, so look two edges after the ratio moves
	task automatic rng(input logic [13:0] t, input tcpr_range_t r, input logic [6:0] a, input logic d);
		@(posedge clk);
		ts_ratio <= t;
		repeat (2) @(posedge clk);
		#1 chk("range", 8'(r), 8'(temp_range));
		chk("active", 8'(a), 8'(active_current_scale));
		chk("double", 8'(d), 8'(timer_double_ok));
	endtask
	// hang guard, the run needs well under this
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			final_report;
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		host.rd(8'h0C, v);
		chk("profile", 8'h75, v);
		rng(14'd6825, TCPR_RANGE_COOL, 7'd20, 1'b1);
		$display("test defaults done");
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h0C, {4{i[1:0]}});
			host.rd(8'h0C, v);
			chk("rw", {4{i[1:0]}}, v);
			chk("warm", 8'(pt[i]), 8'(warm_range_current_scale));
			chk("cool", 8'(pt[i]), 8'(cool_range_current_scale));
			rng(cb[i], TCPR_RANGE_COOL, pt[i], i != 3);
			rng(cb[i] - 14'd1, TCPR_RANGE_NORMAL, 7'd100, 1'b0);
			rng(wb[i], TCPR_RANGE_WARM, pt[i], i != 3);
		end
		host.wr(8'h0D, 8'h00);
		host.rd(8'h0D, v);
		chk("unmapped", 8'h00, v);
		chk("hit", 8'h00, 8'(reg_hit));
		$display("test codes done");
		host.wr(8'h0B, 8'h80);
		@(posedge clk);
		#1 chk("timer rst", 8'h01, 8'(safety_timer_reset));
		host.rd(8'h0B, v);
		chk("rst bit", 8'h00, v);
		chk("timer low", 8'h00, 8'(safety_timer_reset));
		host.rd(8'h0C, v);
		chk("reset load", 8'h75, v);
		$display("test reset done");
		host.wr(8'h0C, 8'h00);
		@(posedge clk);
		wdog_expired <= 1'b1;
		@(posedge clk);
		wdog_expired <= 1'b0;
		host.rd(8'h0C, v);
		chk("wdog load", 8'h75, v);
		chk("fault", 8'h01, 8'(wdog_fault));
		wdog_service <= 1'b1;
		@(posedge clk);
		wdog_service <= 1'b0;
		#1 chk("fault clr", 8'h00, 8'(wdog_fault));
		$display("test watchdog done");
		// a write while the enable is low must not land
		@(posedge clk);
		ce <= 1'b0;
		host.wr(8'h0C, 8'h00);
		ce <= 1'b1;
		host.rd(8'h0C, v);
		chk("frozen", 8'h75, v);
		$display("test enable done");
		final_report;
	end
endmodule // tb_thermal_charge_profile_regs
`default_nettype wire
